//--- hdl/pls_pkg.sv
package pls_pkg;

    // ==========================================================
    // register map (word index, byte address is index * 4)
    localparam logic [7:0] BASIC_CTRL_IDX  = 8'h00;
    localparam logic [7:0] VENDOR_CTRL_IDX = 8'h1E;
    localparam logic [7:0] STATUS_IDX      = 8'h10;

    // basic control fields
    localparam int AUTONEG_BIT   = 12;
    localparam int SPEED_SEL_BIT = 13;
    // vendor control field, two bits from here up
    localparam int LED_MODE_LSB  = 14;
    // status fields
    localparam int ST_LINK_BIT   = 0;
    localparam int ST_SPEED_BIT  = 1;
    localparam int ST_STRAP_LSB  = 2;
    localparam int ST_MODE_LSB   = 5;
    localparam int ST_ACT_BIT    = 7;

    // reset values
    localparam logic       AUTONEG_RST   = 1'b1;
    localparam logic       SPEED_SEL_RST = 1'b1;
    localparam logic [1:0] LED_MODE_RST  = 2'h0;

    // ==========================================================
    // strap pin positions in the sampled vector
    localparam int STRAP_W        = 5;
    localparam int STRAP_COL      = 0;
    localparam int STRAP_CRS      = 1;
    localparam int STRAP_CFG2     = 2;
    localparam int STRAP_LINK_LED = 3;
    localparam int STRAP_SPD_LED  = 4;

    // interface configuration strap codes
    localparam logic [2:0] CFG_MII     = 3'h0;
    localparam logic [2:0] CFG_MII_PRE = 3'h4;
    localparam logic [2:0] CFG_MII_B2B = 3'h6;

    typedef enum logic [1:0] {
        LED_LINK_ACT  = 2'b00,
        LED_LINK_ONLY = 2'b01,
        LED_RSVD_A    = 2'b10,
        LED_RSVD_B    = 2'b11
    } pls_led_mode_t;

    typedef enum logic [1:0] {
        MODE_MII  = 2'b00,
        MODE_PRE  = 2'b01,
        MODE_B2B  = 2'b10,
        MODE_RSVD = 2'b11
    } pls_iface_mode_t;

    // ==========================================================
    // timing: led blink half period
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned BLINK_MS     = 50;
    localparam int unsigned BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);

endpackage

//--- hdl/pls_link_if.sv
interface pls_link_if;
    logic       core_rx_valid;
    logic [3:0] core_rx_nibble;
    logic       mii_rx_dv;
    logic [3:0] mii_rxd;
    logic       mii_tx_en;
    logic [3:0] mii_txd;
    logic       core_tx_valid;
    logic [3:0] core_tx_nibble;
    logic       act_toggle;

    modport frame (
        input  core_rx_valid,
        input  core_rx_nibble,
        output mii_rx_dv,
        output mii_rxd,
        input  mii_tx_en,
        input  mii_txd,
        output core_tx_valid,
        output core_tx_nibble,
        output act_toggle
    );
    modport ctrl (
        output core_rx_valid,
        output core_rx_nibble,
        input  mii_rx_dv,
        input  mii_rxd,
        output mii_tx_en,
        output mii_txd,
        input  core_tx_valid,
        input  core_tx_nibble,
        input  act_toggle
    );
endinterface

//--- hdl/pls_mii_frame.sv
module pls_mii_frame (
    input  wire logic   mii_clk,
    input  wire logic   hresetn,
    pls_link_if.frame   lnk
);
    import pls_pkg::*;

    logic       rst1_reg;
    logic       rst2_reg;
    logic       rx_dv_reg;
    logic       rx_dv_next;
    logic [3:0] rxd_reg;
    logic [3:0] rxd_next;
    logic       tx_valid_reg;
    logic       tx_valid_next;
    logic [3:0] tx_nib_reg;
    logic [3:0] tx_nib_next;
    logic       act_reg;
    logic       act_next;

    // ==========================================================
    // reset release synchronised to the link clock
    always_ff @(posedge mii_clk or negedge hresetn) begin
        if (!hresetn) begin
            rst1_reg <= 1'b0;
            rst2_reg <= 1'b0;
        end else begin
            rst1_reg <= 1'b1;
            rst2_reg <= rst1_reg;
        end
    end

    // ==========================================================
    // rx and tx nibble framing, activity toggle
    always_comb begin
        rx_dv_next    = lnk.core_rx_valid;
        rxd_next      = lnk.core_rx_valid ? lnk.core_rx_nibble : 4'h0;
        tx_valid_next = lnk.mii_tx_en;
        tx_nib_next   = lnk.mii_tx_en ? lnk.mii_txd : 4'h0;
        act_next      = act_reg ^ (lnk.core_rx_valid | lnk.mii_tx_en);
    end

    // every output changes only on the link clock edge
    always_ff @(posedge mii_clk or negedge rst2_reg) begin
        if (!rst2_reg) begin
            rx_dv_reg    <= 1'b0;
            rxd_reg      <= 4'h0;
            tx_valid_reg <= 1'b0;
            tx_nib_reg   <= 4'h0;
            act_reg      <= 1'b0;
        end else begin
            rx_dv_reg    <= rx_dv_next;
            rxd_reg      <= rxd_next;
            tx_valid_reg <= tx_valid_next;
            tx_nib_reg   <= tx_nib_next;
            act_reg      <= act_next;
        end
    end

    assign lnk.mii_rx_dv      = rx_dv_reg;
    assign lnk.mii_rxd        = rxd_reg;
    assign lnk.core_tx_valid  = tx_valid_reg;
    assign lnk.core_tx_nibble = tx_nib_reg;
    assign lnk.act_toggle     = act_reg;

    // ==========================================================
    // checks on the link side
    default clocking cb @(posedge mii_clk); endclocking
    default disable iff (!rst2_reg);

    chk_rxd_gated: assert property (
        !lnk.mii_rx_dv |-> lnk.mii_rxd == 4'h0)
        else $error("rx data not zero while rx valid low");
    chk_rx_follow: assert property (
        lnk.core_rx_valid |=> lnk.mii_rx_dv
            && lnk.mii_rxd == $past(lnk.core_rx_nibble))
        else $error("rx nibble not forwarded one cycle later");
    chk_tx_ignore: assert property (
        !lnk.mii_tx_en |=> !lnk.core_tx_valid
            && lnk.core_tx_nibble == 4'h0)
        else $error("tx data passed while tx enable low");
    chk_tx_sample: assert property (
        lnk.mii_tx_en |=> lnk.core_tx_valid
            && lnk.core_tx_nibble == $past(lnk.mii_txd))
        else $error("tx nibble not sampled on link clock");
endmodule

//--- hdl/pls_top.sv
// How it works
// - one two-bit led mode field in vendor control drives both led pins.
// - mode 00 link led is high without link, low with link, toggles on activity; mode 01 ignores activity.
// - mode 00 speed led is high at 10 and low at 100; mode 01 it is high idle and toggles on activity.
// - collision and carrier sense pins are sampled at reset as strap bits 0 and 1.
// - strap 000 is plain mii, 100 preamble restore, 110 back-to-back, the rest reserved.
// - the link led pin is sampled at reset into autoneg enable, control bit 12.
// - a high autoneg strap enables autoneg, low disables it, pull-up default high.
// - the speed led pin is sampled at reset into speed select, control bit 13.
// - strap pins are inputs during reset and driven outputs after it; here iface_cfg_strap_bit2 stays an input and is never driven.
// - receive nibbles change only on the mii clock edge.
// - receive data is valid only with rx valid, and is zero otherwise.
// - transmit nibbles are ignored while transmit enable is low.
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
module pls_top #(
    parameter int unsigned BLINK_CNT = pls_pkg::BLINK_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        link_up,
    input  wire logic        speed_100,
    input  wire logic        core_col,
    input  wire logic        core_crs,
    input  wire logic        col_pin_level,
    output logic             col_pin_drive,
    output logic             col_pin_oe,
    input  wire logic        crs_pin_level,
    output logic             crs_pin_drive,
    output logic             crs_pin_oe,
    input  wire logic        iface_cfg_strap_bit2,
    input  wire logic        link_led_pin_level,
    output logic             link_led_pin_drive,
    output logic             link_led_pin_oe,
    input  wire logic        speed_led_pin_level,
    output logic             speed_led_pin_drive,
    output logic             speed_led_pin_oe,
    output logic             autoneg_enable,
    output logic             speed_select,
    output pls_pkg::pls_iface_mode_t iface_mode,
    input  wire logic        mii_clk,
    input  wire logic        core_rx_valid,
    input  wire logic [3:0]  core_rx_nibble,
    output logic             mii_rx_dv,
    output logic [3:0]       mii_rxd,
    input  wire logic        mii_tx_en,
    input  wire logic [3:0]  mii_txd,
    output logic             core_tx_valid,
    output logic [3:0]       core_tx_nibble
);
    import pls_pkg::*;

    logic [STRAP_W-1:0] pins;
    logic [STRAP_W-1:0] st1_reg;
    logic [STRAP_W-1:0] st2_reg;
    logic [STRAP_W-1:0] st3_reg;
    logic [STRAP_W-1:0] strap_reg;
    logic [STRAP_W-1:0] strap_next;
    logic               lock1_reg;
    logic               lock2_reg;
    logic [2:0]         cfg_code;
    logic               wr_en_reg;
    logic               wr_en_next;
    logic [7:0]         wr_idx_reg;
    logic [7:0]         wr_idx_next;
    logic               addr_ok;
    logic [31:0]        rd_val;
    logic [31:0]        hrdata_next;
    logic               autoneg_reg;
    logic               autoneg_next;
    logic               spdsel_reg;
    logic               spdsel_next;
    pls_led_mode_t      led_mode_reg;
    pls_led_mode_t      led_mode_next;
    pls_iface_mode_t    mode_reg;
    pls_iface_mode_t    mode_next;
    logic               a1_reg;
    logic               a2_reg;
    logic               a3_reg;
    logic               acc_reg;
    logic               act_evt;
    logic [31:0]        cnt_reg;
    logic [31:0]        cnt_next;
    logic               tick;
    logic               seen_reg;
    logic               seen_next;
    logic               active_reg;
    logic               active_next;
    logic               phase_reg;
    logic               phase_next;
    logic               lled_reg;
    logic               lled_next;
    logic               sled_reg;
    logic               sled_next;
    logic               col_reg;
    logic               crs_reg;

    pls_link_if lnk ();

    // ==========================================================
    // mii framing on the link clock
    pls_mii_frame u_frame (
        .mii_clk (mii_clk),
        .hresetn (hresetn),
        .lnk     (lnk.frame)
    );

    assign lnk.core_rx_valid  = core_rx_valid;
    assign lnk.core_rx_nibble = core_rx_nibble;
    assign lnk.mii_tx_en      = mii_tx_en;
    assign lnk.mii_txd        = mii_txd;
    assign mii_rx_dv          = lnk.mii_rx_dv;
    assign mii_rxd            = lnk.mii_rxd;
    assign core_tx_valid      = lnk.core_tx_valid;
    assign core_tx_nibble     = lnk.core_tx_nibble;

    // ==========================================================
    // strap sampling: three stage synchroniser, held after release
    assign pins[STRAP_COL]      = col_pin_level;
    assign pins[STRAP_CRS]      = crs_pin_level;
    assign pins[STRAP_CFG2]     = iface_cfg_strap_bit2;
    assign pins[STRAP_LINK_LED] = link_led_pin_level;
    assign pins[STRAP_SPD_LED]  = speed_led_pin_level;

    // per bit: take the value once stages two and three agree
    always_comb begin
        for (int i = 0; i < STRAP_W; i++) begin
            strap_next[i] = (!lock1_reg && st2_reg[i] == st3_reg[i])
                            ? st3_reg[i] : strap_reg[i];
        end
    end

    always_ff @(posedge hclk) begin
        st1_reg   <= pins;
        st2_reg   <= st1_reg;
        st3_reg   <= st2_reg;
        strap_reg <= strap_next;
    end

    // lock1 marks the first edge after release, lock2 one later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock1_reg <= 1'b0;
            lock2_reg <= 1'b0;
        end else begin
            lock1_reg <= 1'b1;
            lock2_reg <= lock1_reg;
        end
    end

    assign cfg_code = {strap_reg[STRAP_CFG2], strap_reg[STRAP_CRS],
                       strap_reg[STRAP_COL]};

    // ==========================================================
    // ahb-lite slave: zero wait, always okay
    assign addr_ok = hsel && htrans[1] && hready;

    always_comb begin
        wr_en_next    = addr_ok && hwrite;
        wr_idx_next   = haddr[9:2];
        autoneg_next  = autoneg_reg;
        spdsel_next   = spdsel_reg;
        led_mode_next = led_mode_reg;
        if (lock1_reg && !lock2_reg) begin
            autoneg_next = strap_reg[STRAP_LINK_LED];
            spdsel_next  = strap_reg[STRAP_SPD_LED];
        end else if (wr_en_reg && wr_idx_reg == BASIC_CTRL_IDX) begin
            autoneg_next = hwdata[AUTONEG_BIT];
            spdsel_next  = hwdata[SPEED_SEL_BIT];
        end else if (wr_en_reg && wr_idx_reg == VENDOR_CTRL_IDX) begin
            led_mode_next = pls_led_mode_t'(
                hwdata[LED_MODE_LSB+1:LED_MODE_LSB]);
        end
        // read uses post-write values so back-to-back access is coherent
        rd_val = 32'h0;
        case (haddr[9:2])
            BASIC_CTRL_IDX: begin
                rd_val[AUTONEG_BIT]   = autoneg_next;
                rd_val[SPEED_SEL_BIT] = spdsel_next;
            end
            VENDOR_CTRL_IDX: begin
                rd_val[LED_MODE_LSB+1:LED_MODE_LSB] = led_mode_next;
            end
            STATUS_IDX: begin
                rd_val[ST_LINK_BIT]  = link_up;
                rd_val[ST_SPEED_BIT] = speed_100;
                rd_val[ST_STRAP_LSB+2:ST_STRAP_LSB] = cfg_code;
                rd_val[ST_MODE_LSB+1:ST_MODE_LSB]   = mode_reg;
                rd_val[ST_ACT_BIT]   = active_reg;
            end
            default: rd_val = 32'h0;
        endcase
        hrdata_next = (addr_ok && !hwrite) ? rd_val : hrdata;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_en_reg    <= 1'b0;
            wr_idx_reg   <= 8'h00;
            hrdata       <= 32'h0;
            hreadyout    <= 1'b0;
            hresp        <= 1'b0;
            autoneg_reg  <= AUTONEG_RST;
            spdsel_reg   <= SPEED_SEL_RST;
            led_mode_reg <= pls_led_mode_t'(LED_MODE_RST);
        end else begin
            wr_en_reg    <= wr_en_next;
            wr_idx_reg   <= wr_idx_next;
            hrdata       <= hrdata_next;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
            autoneg_reg  <= autoneg_next;
            spdsel_reg   <= spdsel_next;
            led_mode_reg <= led_mode_next;
        end
    end

    // ==========================================================
    // interface mode decode from the held strap
    always_comb begin
        case (cfg_code)
            CFG_MII:     mode_next = MODE_MII;
            CFG_MII_PRE: mode_next = MODE_PRE;
            CFG_MII_B2B: mode_next = MODE_B2B;
            default:     mode_next = MODE_RSVD;
        endcase
    end

    // ==========================================================
    // activity toggle crossing from the link clock
    assign act_evt = (a2_reg == a3_reg) && (a3_reg != acc_reg);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a1_reg  <= 1'b0;
            a2_reg  <= 1'b0;
            a3_reg  <= 1'b0;
            acc_reg <= 1'b0;
        end else begin
            a1_reg  <= lnk.act_toggle;
            a2_reg  <= a1_reg;
            a3_reg  <= a2_reg;
            acc_reg <= (a2_reg == a3_reg) ? a3_reg : acc_reg;
        end
    end

    // ==========================================================
    // blink timer and led pin values
    assign tick = (cnt_reg == BLINK_CNT - 1);

    always_comb begin
        cnt_next    = tick ? 32'h0 : cnt_reg + 32'h1;
        // a new event wins over the clear at a tick
        seen_next   = tick ? act_evt : (seen_reg | act_evt);
        active_next = tick ? (seen_reg | act_evt) : active_reg;
        phase_next  = (tick && active_reg) ? !phase_reg : phase_reg;
        case (led_mode_reg)
            LED_LINK_ACT: begin
                lled_next = !link_up ? 1'b1
                          : (active_reg ? phase_reg : 1'b0);
                sled_next = !speed_100;
            end
            LED_LINK_ONLY: begin
                lled_next = !link_up;
                sled_next = active_reg ? phase_reg : 1'b1;
            end
            default: begin
                lled_next = 1'b1;
                sled_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg    <= 32'h0;
            seen_reg   <= 1'b0;
            active_reg <= 1'b0;
            phase_reg  <= 1'b0;
            lled_reg   <= 1'b1;
            sled_reg   <= 1'b1;
            col_reg    <= 1'b0;
            crs_reg    <= 1'b0;
            mode_reg   <= MODE_MII;
        end else begin
            cnt_reg    <= cnt_next;
            seen_reg   <= seen_next;
            active_reg <= active_next;
            phase_reg  <= phase_next;
            lled_reg   <= lled_next;
            sled_reg   <= sled_next;
            col_reg    <= core_col;
            crs_reg    <= core_crs;
            mode_reg   <= mode_next;
        end
    end

    // ==========================================================
    // pin drivers: enables stay low until after reset release
    assign col_pin_drive       = col_reg;
    assign crs_pin_drive       = crs_reg;
    assign link_led_pin_drive  = lled_reg;
    assign speed_led_pin_drive = sled_reg;
    assign col_pin_oe          = lock1_reg;
    assign crs_pin_oe          = lock1_reg;
    assign link_led_pin_oe     = lock1_reg;
    assign speed_led_pin_oe    = lock1_reg;
    assign autoneg_enable      = autoneg_reg;
    assign speed_select        = spdsel_reg;
    assign iface_mode          = mode_reg;

    // ==========================================================
    // checks on the register side
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence rsvd_two;
        led_mode_reg[1] [*2];
    endsequence
    sequence m00_two;
        (led_mode_reg == LED_LINK_ACT) [*2];
    endsequence
    sequence m01_two;
        (led_mode_reg == LED_LINK_ONLY) [*2];
    endsequence

    chk_led_reserved: assert property (
        rsvd_two |-> link_led_pin_drive && speed_led_pin_drive)
        else $error("reserved led mode not high");
    chk_speed_led_mode: assert property (
        m00_two |-> speed_led_pin_drive == !$past(speed_100))
        else $error("speed led wrong in mode 00");
    chk_link_led_only: assert property (
        m01_two |-> link_led_pin_drive == !$past(link_up))
        else $error("link led wrong in mode 01");
    chk_pins_input: assert property (
        !lock1_reg |-> !col_pin_oe && !crs_pin_oe
            && !link_led_pin_oe && !speed_led_pin_oe)
        else $error("strap pin driven during reset");
    chk_strap_frozen: assert property (
        lock1_reg && $past(lock1_reg) |-> $stable(strap_reg))
        else $error("strap changed after release");
    chk_autoneg_load: assert property (
        lock1_reg && !lock2_reg |=>
            autoneg_enable == $past(strap_reg[STRAP_LINK_LED]))
        else $error("autoneg not loaded from strap");
    chk_speed_load: assert property (
        lock1_reg && !lock2_reg |=>
            speed_select == $past(strap_reg[STRAP_SPD_LED]))
        else $error("speed select not loaded from strap");
    chk_mode_decode: assert property (
        lock2_reg |-> (iface_mode == MODE_PRE) == (cfg_code == CFG_MII_PRE)
            && (iface_mode == MODE_B2B) == (cfg_code == CFG_MII_B2B)
            && (iface_mode == MODE_MII) == (cfg_code == CFG_MII))
        else $error("interface strap not decoded");
endmodule

//--- tb/pls_mac_model.sv
module pls_mac_model (
    input  wire logic       mii_clk,
    input  wire logic       en,
    input  wire logic [7:0] pick,
    input  wire logic       rx_dv,
    input  wire logic [3:0] rxd,
    output logic            tx_en,
    output logic [3:0]      txd,
    output int              rx_count
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        tx_en = 1'b0;
        txd = 4'h0;
        rx_count = 0;
    end

    // ==========================================================
    // mac side: send on the link clock, take nibbles only when valid
    always @(posedge mii_clk) begin
        if (en && pick[0]) begin
            tx_en <= 1'b1;
            txd <= pick[4:1];
        end else begin
            tx_en <= 1'b0;
            txd <= ~txd; // idle data lines do not hold the last value
        end
        if (rx_dv === 1'b1) begin
            rx_count <= rx_count + 1;
        end
    end
endmodule

//--- tb/test_phy_led_strap_mii_pins.sv
module test_phy_led_strap_mii_pins;
    import pls_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans, tog;
    logic [2:0] hsize;
    logic link_up, speed_100, core_col, core_crs, iface_cfg_strap_bit2;
    logic col_pin_level, col_pin_drive, col_pin_oe;
    logic crs_pin_level, crs_pin_drive, crs_pin_oe;
    logic link_led_pin_level, link_led_pin_drive, link_led_pin_oe;
    logic speed_led_pin_level, speed_led_pin_drive, speed_led_pin_oe;
    logic autoneg_enable, speed_select, mii_clk, core_rx_valid;
    logic mii_rx_dv, mii_tx_en, core_tx_valid, traffic, chk_mii;
    logic [3:0] core_rx_nibble, mii_rxd, mii_txd, core_tx_nibble;
    logic s_col, s_crs, s_lnk, s_spd, b;
    logic [7:0] rnd;
    logic [4:0] erx, etx;
    pls_iface_mode_t iface_mode;
    int fails, tests_run, rx_seen, rx_count;

    pls_top #(.BLINK_CNT(16)) dut (.*);
    pls_mac_model mac (.mii_clk(mii_clk), .en(traffic), .pick(rnd),
        .rx_dv(mii_rx_dv), .rxd(mii_rxd), .tx_en(mii_tx_en),
        .txd(mii_txd), .rx_count(rx_count));

    // ==========================================================
    // pin levels: driven value, else strap or pull level
    assign hready = hreadyout;
    assign col_pin_level = col_pin_oe ? col_pin_drive : s_col;
    assign crs_pin_level = crs_pin_oe ? crs_pin_drive : s_crs;
    assign link_led_pin_level = link_led_pin_oe ? link_led_pin_drive : s_lnk;
    assign speed_led_pin_level = speed_led_pin_oe ? speed_led_pin_drive
                                                  : s_spd;

    // clocks, the link clock unrelated in phase
    always #5 hclk = ~hclk;
    initial begin
        mii_clk = 1'b0;
        #7;
        forever #40 mii_clk = ~mii_clk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // expected {speed led, link led} with no activity
    function automatic logic [1:0] led_exp(input int m, input logic l,
                                           input logic s);
        if (m == 0) return {!s, !l};
        if (m == 1) return {1'b1, !l};
        return 2'b11;
    endfunction

    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // one single transfer, entered right after a rising edge
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // link side stimulus and per-edge comparison with the model
    always @(posedge mii_clk) begin
        rnd <= lfsr(rnd);
        core_rx_valid <= traffic & rnd[5];
        core_rx_nibble <= rnd[7:4];
        erx = core_rx_valid ? {1'b1, core_rx_nibble} : 5'h00;
        etx = mii_tx_en ? {1'b1, mii_txd} : 5'h00;
        if (chk_mii) begin
            #1;
            check("rx", {27'h0, erx}, {27'h0, mii_rx_dv, mii_rxd});
            check("tx", {27'h0, etx}, {27'h0, core_tx_valid, core_tx_nibble});
            if (erx[4]) rx_seen++;
        end
    end

    initial begin
        #100000;
        fails++;
        complete_run();
    end

    // ==========================================================
    // main sequence
    initial begin
        {hclk, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hresetn = 1'b1;
        {link_up, speed_100, core_col, core_crs, traffic, chk_mii} = '0;
        {core_rx_valid, core_rx_nibble} = '0;
        hsize = 3'h2;
        rnd = 8'h30;
        {s_col, s_crs, iface_cfg_strap_bit2, s_lnk, s_spd} = 5'b01101;
        // a clean falling edge so both clock domains see the reset
        #1;
        hresetn = 1'b0;
        repeat (5) @(posedge hclk);
        check("oe_rst", 32'h0, {28'h0, col_pin_oe, crs_pin_oe,
              link_led_pin_oe, speed_led_pin_oe});
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        #1;
        check("autoneg", 32'h0, {31'h0, autoneg_enable});
        check("speed_sel", 32'h1, {31'h0, speed_select});
        check("mode", {30'h0, MODE_B2B}, {30'h0, iface_mode});
        check("oe", 32'hF, {28'h0, col_pin_oe, crs_pin_oe,
              link_led_pin_oe, speed_led_pin_oe});
        @(posedge hclk);
        {s_col, s_crs, iface_cfg_strap_bit2, s_lnk, s_spd} <= 5'b10010;
        core_col <= 1'b1;
        repeat (3) @(posedge hclk);
        check("col_crs", 32'h2, {30'h0, col_pin_drive, crs_pin_drive});
        ahb(1'b0, {22'h0, STATUS_IDX, 2'h0}, 32'h0, r);
        check("straps", {25'h0, MODE_B2B, 3'b110, speed_100, link_up},
              {25'h0, r[6:0]});
        ahb(1'b0, {22'h0, BASIC_CTRL_IDX, 2'h0}, 32'h0, r);
        check("ctrl", 32'h2, {30'h0, r[13:12]});
        ahb(1'b0, 32'h3FC, 32'h0, r);
        check("unmapped", 32'h0, r);
        for (int m = 0; m < 4; m++) begin
            ahb(1'b1, {22'h0, VENDOR_CTRL_IDX, 2'h0}, 32'(m) << 14, r);
            ahb(1'b0, {22'h0, VENDOR_CTRL_IDX, 2'h0}, 32'h0, r);
            check("led_mode", 32'(m), {30'h0, r[15:14]});
            repeat (6) begin
                link_up <= rnd[1];
                speed_100 <= rnd[2];
                repeat (4) @(posedge hclk);
                check("leds", {30'h0, led_exp(m, link_up, speed_100)},
                      {30'h0, speed_led_pin_drive, link_led_pin_drive});
            end
        end
        chk_mii <= 1'b1;
        traffic <= 1'b1;
        link_up <= 1'b1;
        // with traffic running, the activity led of modes 00 and 01 must blink
        for (int m = 0; m < 2; m++) begin
            ahb(1'b1, {22'h0, VENDOR_CTRL_IDX, 2'h0}, 32'(m) << 14, r);
            tog = 2'b00;
            repeat (100) begin
                @(posedge hclk);
                #1;
                b = m ? speed_led_pin_drive : link_led_pin_drive;
                tog = tog | {b, !b};
            end
            check("blink", 32'h3, {30'h0, tog});
            @(posedge hclk);
        end
        repeat (300) @(posedge mii_clk);
        traffic <= 1'b0;
        repeat (4) @(posedge mii_clk);
        check("rx_count", 32'(rx_seen), 32'(rx_count));
        complete_run();
    end
endmodule
